// ---- src/interrupt_entry_sequencer.sv ----
`timescale 1ns/1ps
// Behaviour
// RL1: Ordinary instruction finishes, then entry next cycle
// RL2: String or multiply-accumulate instructions suspend for entry
// RL3: Fetch info word, clear matching request bit
// RL4: Copy pre-entry flag word to hidden temp
// RL5: Clear mask, debug, stack select; traps 32-63 keep select
// RL6: Push flag copy, or flag shadow when fast
// RL7: Push program counter, or pc shadow when fast
// RL8: Load priority level and start handler in the same cycle
// RL9: Extended divide worst wait 24 cycles
// RL10: Memory divisor adds mode-dependent wait cycles
// RL11: Odd or 8-bit areas double wait counts
// RL12: Peripheral and trap entry lengths per bus
// RL13: Fixed-vector entry 13/15, overflow 14/16
// RL14: Relocatable break entry 17/19 cycles
// RL15: Step, second break, fixed break 19/21
// RL16: Fast entry always 5 cycles
// RL17: Levelless sources set level 7, 0, unchanged
// RL18: Stack entry saves only flag and pc
// RL19: Push flag, then pc high, then low
// RL20: Handler return restores flag and pc from stack
// RL21: Fast return restores from shadow registers
// RL22: Software should keep vectors at even addresses
// RL23: Maskable accept needs mask, request, higher level
// RL24: Fixed priority reset, nmi, watchdog, peripheral, step, match
// RL25: Counts in cpu clocks; reset returns to idle
module interrupt_entry_sequencer
   import irq_seq_pkg::*;
(
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_reset_irq,
   input  wire logic              i_nmi_req,
   input  wire logic              i_wdt_req,
   input  wire logic              i_periph_req,
   input  wire logic [2:0]        i_periph_level,
   input  wire logic              i_periph_fast,
   input  wire logic              i_step_req,
   input  wire logic              i_amatch_req,
   input  wire logic              i_trap_req,
   input  class_t                 i_trap_class,
   input  wire logic [5:0]        i_trap_num,
   input  wire logic              i_instr_done,
   input  wire logic              i_string_busy,
   input  wire logic [15:0]       i_flag_word,
   input  wire logic [ADDR_W-1:0] i_pc,
   input  wire logic              i_bus8,
   input  wire logic              i_vec_odd,
   input  wire logic [15:0]       i_mem_rdata,
   input  wire logic              i_ret_req,
   input  wire logic              i_fast_ret_req,
   input  wire logic              i_div_mem,
   input  div_mode_t              i_div_mode,
   input  wire logic [3:0]        i_div_wait_x,
   input  wire logic [3:0]        i_div_wait_y,
   input  wire logic              i_div_x_double,
   input  wire logic              i_div_y_double,
   output logic                   o_busy,
   output logic                   o_suspend,
   output logic                   o_info_rd,
   output logic                   o_req_clear,
   output logic [ADDR_W-1:0]      o_mem_addr,
   output logic                   o_push,
   output logic                   o_pop,
   output logic [15:0]            o_mem_wdata,
   output logic                   o_flag_wr,
   output logic [15:0]            o_flag_out,
   output logic                   o_pc_wr,
   output logic [ADDR_W-1:0]      o_pc_out,
   output logic                   o_handler_go,
   output logic                   o_resume,
   output logic [7:0]             o_int_number,
   output logic [15:0]            o_flag_shadow,
   output logic [ADDR_W-1:0]      o_pc_shadow,
   output logic [4:0]             o_entry_cycles,
   output logic [7:0]             o_divide_cycles
);
   // ==========================================================
   // Request selection
   state_t            state_q, state_d;
   class_t            class_q, class_d, sel_class;
   logic [4:0]        cnt_q, cnt_d, len_q, len_d, sel_len;
   logic [15:0]       temp_q, temp_d, lo_q, lo_d, hi_q, hi_d;
   logic [15:0]       fshadow_q, fshadow_d;
   logic [ADDR_W-1:0] pc_q, pc_d, pshadow_q, pshadow_d;
   logic [2:0]        level_q, level_d, new_ipl;
   logic              ukeep_q, ukeep_d, sel_valid, periph_ok, accept;
   logic [5:0]        tnum_q, tnum_d;
   logic              suspend_d, info_rd_d, push_d, pop_d, flag_wr_d, pc_wr_d;
   logic              go_d, resume_d;
   logic [ADDR_W-1:0] mem_addr_d, pc_out_d;
   logic [15:0]       wdata_d, flag_out_d;
   logic [7:0]        number_q, number_d;

   assign periph_ok = i_periph_req && i_flag_word[FLAG_I_BIT] &&
                      (i_periph_level > i_flag_word[FLAG_IPL_LSB +: 3]); // [RL23]

   always_comb begin
      sel_valid = 1'b1;
      if (i_reset_irq)       sel_class = CL_RESET; // [RL24]
      else if (i_nmi_req)    sel_class = CL_NMI;
      else if (i_wdt_req)    sel_class = CL_WDT;
      else if (periph_ok)    sel_class = i_periph_fast ? CL_FAST : CL_PERIPH;
      else if (i_step_req)   sel_class = CL_STEP;
      else if (i_amatch_req) sel_class = CL_AMATCH;
      else if (i_trap_req)   sel_class = i_trap_class;
      else begin
         sel_class = CL_PERIPH;
         sel_valid = 1'b0;
      end
   end

   entry_time_calc u_entry_time (
      .i_class  (sel_class),
      .i_bus8   (i_bus8),
      .i_vec_odd(i_vec_odd),
      .o_cycles (sel_len)
   );

   divide_time_calc u_divide_time (
      .i_mem_divisor(i_div_mem),
      .i_mode       (i_div_mode),
      .i_wait_x     (i_div_wait_x),
      .i_wait_y     (i_div_wait_y),
      .i_x_double   (i_div_x_double),
      .i_y_double   (i_div_y_double),
      .o_cycles     (o_divide_cycles)
   );

   // ==========================================================
   // Sequencer next state
   always_comb begin
      state_d    = state_q;
      class_d    = class_q;
      cnt_d      = cnt_q;
      len_d      = len_q;
      temp_d     = temp_q;
      pc_d       = pc_q;
      level_d    = level_q;
      ukeep_d    = ukeep_q;
      tnum_d     = tnum_q;
      lo_d       = lo_q;
      hi_d       = hi_q;
      fshadow_d  = fshadow_q;
      pshadow_d  = pshadow_q;
      number_d   = number_q;
      suspend_d  = 1'b0;
      info_rd_d  = 1'b0;
      push_d     = 1'b0;
      pop_d      = 1'b0;
      flag_wr_d  = 1'b0;
      pc_wr_d    = 1'b0;
      go_d       = 1'b0;
      resume_d   = 1'b0;
      mem_addr_d = o_mem_addr;
      wdata_d    = o_mem_wdata;
      flag_out_d = o_flag_out;
      pc_out_d   = o_pc_out;
      accept     = 1'b0;
      new_ipl    = temp_q[FLAG_IPL_LSB +: 3];
      unique case (state_q)
         ST_IDLE: begin
            if (i_ret_req) begin
               state_d = ST_RET_STACK;
               cnt_d   = CNT_RST;
            end else if (i_fast_ret_req) begin
               state_d = ST_RET_FAST;
            end else if (sel_valid) begin
               accept = i_instr_done || i_string_busy; // [RL1]
               if (!accept) state_d = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (!sel_valid) state_d = ST_IDLE;
            else accept = i_instr_done || i_string_busy; // [RL1]
         end
         ST_ENTRY: begin
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == STEP_INFO && (class_q == CL_PERIPH || class_q == CL_FAST)) begin
               info_rd_d  = 1'b1; // [RL3]
               mem_addr_d = (class_q == CL_FAST) ? FAST_INFO_ADDR : INFO_ADDR;
            end
            if (cnt_q == STEP_MASK) begin
               flag_wr_d  = 1'b1;
               flag_out_d = temp_q;
               flag_out_d[FLAG_I_BIT] = 1'b0; // [RL5]
               flag_out_d[FLAG_D_BIT] = 1'b0;
               if (!ukeep_q) flag_out_d[FLAG_U_BIT] = 1'b0;
            end
            if (class_q == CL_FAST) begin
               if (cnt_q == STEP_FLAG) fshadow_d = temp_q; // [RL6]
               if (cnt_q == STEP_PC_HI) pshadow_d = pc_q; // [RL7]
            end else begin
               // Only flag and pc ever reach the stack
               push_d = (cnt_q == STEP_FLAG) || (cnt_q == STEP_PC_HI) ||
                        (cnt_q == STEP_PC_LO); // [RL18]
               if (cnt_q == STEP_FLAG) wdata_d = temp_q; // [RL6] [RL19]
               if (cnt_q == STEP_PC_HI) wdata_d = {8'h00, pc_q[23:16]}; // [RL7] [RL19]
               if (cnt_q == STEP_PC_LO) wdata_d = pc_q[15:0]; // [RL19]
            end
            if (cnt_q == len_q - 5'h01) begin
               unique case (class_q)
                  CL_PERIPH, CL_FAST: new_ipl = level_q; // [RL8]
                  CL_NMI, CL_WDT:     new_ipl = IPL_TOP; // [RL17]
                  CL_RESET:           new_ipl = IPL_RESET; // [RL17]
                  default:            new_ipl = temp_q[FLAG_IPL_LSB +: 3];
               endcase
               flag_wr_d  = 1'b1;
               flag_out_d = o_flag_out;
               flag_out_d[FLAG_IPL_LSB +: 3] = new_ipl; // [RL8]
               go_d       = 1'b1;
               state_d    = ST_IDLE;
               cnt_d      = CNT_RST;
            end
         end
         ST_RET_STACK: begin
            cnt_d = cnt_q + 5'h01;
            pop_d = (cnt_q < RET_LAST); // [RL20]
            // Popped word valid with pop strobe
            if (cnt_q == 5'h01) lo_d = i_mem_rdata;
            if (cnt_q == 5'h02) hi_d = i_mem_rdata;
            if (cnt_q == RET_LAST) begin
               flag_wr_d  = 1'b1; // [RL20]
               flag_out_d = i_mem_rdata;
               pc_wr_d    = 1'b1;
               pc_out_d   = {hi_q[7:0], lo_q};
               resume_d   = 1'b1;
               state_d    = ST_IDLE;
               cnt_d      = CNT_RST;
            end
         end
         ST_RET_FAST: begin
            flag_wr_d  = 1'b1; // [RL21]
            flag_out_d = fshadow_q;
            pc_wr_d    = 1'b1;
            pc_out_d   = pshadow_q;
            resume_d   = 1'b1;
            state_d    = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
      if (accept) begin
         suspend_d = i_string_busy && !i_instr_done; // [RL2]
         state_d   = ST_ENTRY;
         class_d   = sel_class;
         len_d     = sel_len;
         cnt_d     = CNT_RST;
         temp_d    = i_flag_word; // [RL4]
         pc_d      = i_pc;
         level_d   = i_periph_level;
         tnum_d    = i_trap_num;
         ukeep_d   = (sel_class == CL_TRAP) && (i_trap_num >= TRAP_UKEEP_LO) &&
                     (i_trap_num <= TRAP_UKEEP_HI); // [RL5]
      end
      if (o_info_rd) begin
         number_d = i_mem_rdata[7:0]; // [RL3]
         level_d  = i_mem_rdata[10:8];
      end else if (go_d && class_q == CL_TRAP) begin
         number_d = {2'h0, tnum_q};
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q       <= ST_IDLE; // [RL25]
         class_q       <= CL_PERIPH;
         cnt_q         <= CNT_RST;
         len_q         <= CYC_FAST;
         temp_q        <= FLAG_RST;
         pc_q          <= '0;
         level_q       <= 3'h0;
         ukeep_q       <= 1'b0;
         tnum_q        <= 6'h00;
         lo_q          <= 16'h0000;
         hi_q          <= 16'h0000;
         fshadow_q     <= FLAG_RST;
         pshadow_q     <= '0;
         number_q      <= 8'h00;
         o_suspend     <= 1'b0;
         o_info_rd     <= 1'b0;
         o_push        <= 1'b0;
         o_pop         <= 1'b0;
         o_flag_wr     <= 1'b0;
         o_pc_wr       <= 1'b0;
         o_handler_go  <= 1'b0;
         o_resume      <= 1'b0;
         o_mem_addr    <= '0;
         o_mem_wdata   <= 16'h0000;
         o_flag_out    <= FLAG_RST;
         o_pc_out      <= '0;
      end else begin
         state_q       <= state_d;
         class_q       <= class_d;
         cnt_q         <= cnt_d;
         len_q         <= len_d;
         temp_q        <= temp_d;
         pc_q          <= pc_d;
         level_q       <= level_d;
         ukeep_q       <= ukeep_d;
         tnum_q        <= tnum_d;
         lo_q          <= lo_d;
         hi_q          <= hi_d;
         fshadow_q     <= fshadow_d;
         pshadow_q     <= pshadow_d;
         number_q      <= number_d;
         o_suspend     <= suspend_d;
         o_info_rd     <= info_rd_d;
         o_push        <= push_d;
         o_pop         <= pop_d;
         o_flag_wr     <= flag_wr_d;
         o_pc_wr       <= pc_wr_d;
         o_handler_go  <= go_d;
         o_resume      <= resume_d;
         o_mem_addr    <= mem_addr_d;
         o_mem_wdata   <= wdata_d;
         o_flag_out    <= flag_out_d;
         o_pc_out      <= pc_out_d;
      end
   end

   assign o_req_clear    = o_info_rd; // [RL3]
   assign o_busy         = (state_q != ST_IDLE);
   assign o_int_number   = number_q;
   assign o_flag_shadow  = fshadow_q;
   assign o_pc_shadow    = pshadow_q;
   assign o_entry_cycles = len_q;

   // ==========================================================
   // Checks
   property p_wait_done;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == ST_WAIT && !i_instr_done && !i_string_busy) |=> state_q != ST_ENTRY;
   endproperty
   a_wait_done: assert property (p_wait_done) else $error("entry before done"); // [RL1]

   property p_info_fetch;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == ST_ENTRY && cnt_q == STEP_INFO && class_q == CL_FAST)
      |=> o_info_rd && o_req_clear && o_mem_addr == FAST_INFO_ADDR;
   endproperty
   a_info_fetch: assert property (p_info_fetch) else $error("fast info read bad"); // [RL3]

   property p_mask_clear;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == ST_ENTRY && cnt_q == STEP_MASK)
      |=> o_flag_wr && !o_flag_out[FLAG_I_BIT] && !o_flag_out[FLAG_D_BIT];
   endproperty
   a_mask_clear: assert property (p_mask_clear) else $error("mask not cleared"); // [RL5]

   property p_push_order;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == ST_ENTRY && cnt_q == STEP_FLAG && class_q != CL_FAST)
      |=> (o_push && o_mem_wdata == temp_q) ##1 (o_push && o_mem_wdata[7:0] == pc_q[23:16])
          ##1 (o_push && o_mem_wdata == pc_q[15:0]) ##1 !o_push;
   endproperty
   a_push_order: assert property (p_push_order) else $error("push order wrong"); // [RL19]

   property p_fast_len;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(state_q == ST_ENTRY) && class_q == CL_FAST)
      |-> (state_q == ST_ENTRY && !o_push)[*5] ##1 (state_q == ST_IDLE && o_handler_go);
   endproperty
   a_fast_len: assert property (p_fast_len) else $error("fast entry not 5"); // [RL16]

   property p_nmi_ipl;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (o_handler_go && (class_q == CL_NMI || class_q == CL_WDT))
      |-> o_flag_out[FLAG_IPL_LSB +: 3] == IPL_TOP;
   endproperty
   a_nmi_ipl: assert property (p_nmi_ipl) else $error("level not 7"); // [RL17]

   property p_periph_len;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      ($rose(state_q == ST_ENTRY) && class_q == CL_PERIPH && !$past(i_vec_odd) && !$past(i_bus8))
      |-> len_q == CYC_PERIPH_16;
   endproperty
   a_periph_len: assert property (p_periph_len) else $error("peripheral length"); // [RL12]

   property p_fast_return;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      (state_q == ST_RET_FAST)
      |=> o_resume && o_flag_out == $past(fshadow_q) && o_pc_out == $past(pshadow_q);
   endproperty
   a_fast_return: assert property (p_fast_return) else $error("fast return bad"); // [RL21]

   property p_stack_return;
      @(posedge i_ref_clk) disable iff (!i_rst_n)
      $rose(state_q == ST_RET_STACK) |-> ##1 o_pop[*3] ##1 (o_resume && o_pc_wr && !o_pop);
   endproperty
   a_stack_return: assert property (p_stack_return) else $error("stack return bad"); // [RL20]
endmodule : interrupt_entry_sequencer

// ---- src/irq_seq_pkg.sv ----
package irq_seq_pkg;
   // ==========================================================
   // Widths and fixed addresses
   localparam int          ADDR_W         = 24;
   localparam int          DATA_W         = 16;
   localparam logic [23:0] INFO_ADDR      = 24'h000000;
   localparam logic [23:0] FAST_INFO_ADDR = 24'h000002;
   // ==========================================================
   // Flag word layout
   localparam int          FLAG_D_BIT     = 2;
   localparam int          FLAG_I_BIT     = 6;
   localparam int          FLAG_U_BIT     = 7;
   localparam int          FLAG_IPL_LSB   = 12;
   localparam logic [2:0]  IPL_TOP        = 3'h7;
   localparam logic [2:0]  IPL_RESET      = 3'h0;
   localparam logic [5:0]  TRAP_UKEEP_LO  = 6'h20;
   localparam logic [5:0]  TRAP_UKEEP_HI  = 6'h3F;
   localparam logic [15:0] FLAG_RST       = 16'h0000;
   // ==========================================================
   // Entry sequence lengths in clock cycles
   localparam logic [4:0]  CYC_PERIPH_16  = 5'h0E;
   localparam logic [4:0]  CYC_PERIPH_8   = 5'h10;
   localparam logic [4:0]  CYC_PERIPH_ODD = 5'h10;
   localparam logic [4:0]  CYC_TRAP_16    = 5'h0C;
   localparam logic [4:0]  CYC_TRAP_8     = 5'h0E;
   localparam logic [4:0]  CYC_TRAP_ODD   = 5'h0E;
   localparam logic [4:0]  CYC_FIXED_16   = 5'h0D;
   localparam logic [4:0]  CYC_FIXED_8    = 5'h0F;
   localparam logic [4:0]  CYC_OVF_16     = 5'h0E;
   localparam logic [4:0]  CYC_OVF_8      = 5'h10;
   localparam logic [4:0]  CYC_BRKV_16    = 5'h11;
   localparam logic [4:0]  CYC_BRKV_8     = 5'h13;
   localparam logic [4:0]  CYC_BRKV_ODD   = 5'h13;
   localparam logic [4:0]  CYC_DBG_16     = 5'h13;
   localparam logic [4:0]  CYC_DBG_8      = 5'h15;
   localparam logic [4:0]  CYC_FAST       = 5'h05;
   // ==========================================================
   // Extended divide timing
   localparam logic [7:0]  DIV_BASE       = 8'h18;
   localparam logic [7:0]  DIV_ADD_NORM   = 8'h02;
   localparam logic [7:0]  DIV_ADD_INDEX  = 8'h03;
   localparam logic [7:0]  DIV_ADD_IND    = 8'h05;
   localparam logic [7:0]  DIV_ADD_INDIDX = 8'h06;
   // ==========================================================
   // Entry step positions and reset values
   localparam logic [4:0]  STEP_INFO      = 5'h00;
   localparam logic [4:0]  STEP_MASK      = 5'h02;
   localparam logic [4:0]  STEP_FLAG      = 5'h03;
   localparam logic [4:0]  STEP_PC_HI     = 5'h04;
   localparam logic [4:0]  STEP_PC_LO     = 5'h05;
   localparam logic [4:0]  RET_LAST       = 5'h03;
   localparam logic [4:0]  CNT_RST        = 5'h00;

   typedef enum logic [3:0] {
      CL_PERIPH, CL_FAST, CL_TRAP, CL_NMI, CL_WDT, CL_UNDEF, CL_AMATCH,
      CL_OVF, CL_BRK_VAR, CL_BRK_FIX, CL_SECOND_BREAK_INSTRUCTION, CL_STEP, CL_RESET
   } class_t;

   typedef enum logic [1:0] {AM_NORMAL, AM_INDEX, AM_INDIRECT, AM_IND_INDEX} div_mode_t;

   typedef enum logic [4:0] {
      ST_IDLE      = 5'b00001,
      ST_WAIT      = 5'b00010,
      ST_ENTRY     = 5'b00100,
      ST_RET_STACK = 5'b01000,
      ST_RET_FAST  = 5'b10000
   } state_t;
endpackage : irq_seq_pkg

// ---- src/entry_time_calc.sv ----
`timescale 1ns/1ps
module entry_time_calc
   import irq_seq_pkg::*;
(
   input  class_t     i_class,
   input  wire logic  i_bus8,
   input  wire logic  i_vec_odd,
   output logic [4:0] o_cycles
);
   // ==========================================================
   // Sequence length per interrupt class
   always_comb begin
      unique case (i_class)
         CL_PERIPH:  o_cycles = i_vec_odd ? CYC_PERIPH_ODD :
                                (i_bus8 ? CYC_PERIPH_8 : CYC_PERIPH_16); // [RL12]
         CL_TRAP:    o_cycles = i_vec_odd ? CYC_TRAP_ODD :
                                (i_bus8 ? CYC_TRAP_8 : CYC_TRAP_16); // [RL12]
         CL_NMI, CL_WDT, CL_UNDEF, CL_AMATCH, CL_RESET:
                     o_cycles = i_bus8 ? CYC_FIXED_8 : CYC_FIXED_16; // [RL13]
         CL_OVF:     o_cycles = i_bus8 ? CYC_OVF_8 : CYC_OVF_16; // [RL13]
         CL_BRK_VAR: o_cycles = i_vec_odd ? CYC_BRKV_ODD :
                                (i_bus8 ? CYC_BRKV_8 : CYC_BRKV_16); // [RL14]
         CL_BRK_FIX, CL_SECOND_BREAK_INSTRUCTION, CL_STEP:
                     o_cycles = i_bus8 ? CYC_DBG_8 : CYC_DBG_16; // [RL15]
         CL_FAST:    o_cycles = CYC_FAST; // [RL16]
         default:    o_cycles = CYC_FIXED_16;
      endcase
   end
endmodule : entry_time_calc

// ---- src/divide_time_calc.sv ----
`timescale 1ns/1ps
module divide_time_calc
   import irq_seq_pkg::*;
(
   input  wire logic       i_mem_divisor,
   input  div_mode_t       i_mode,
   input  wire logic [3:0] i_wait_x,
   input  wire logic [3:0] i_wait_y,
   input  wire logic       i_x_double,
   input  wire logic       i_y_double,
   output logic [7:0]      o_cycles
);
   logic [7:0] x_eff;
   logic [7:0] y_eff;
   logic [7:0] add;

   // ==========================================================
   // Worst-case wait for the instruction in flight
   always_comb begin
      x_eff = i_x_double ? {3'h0, i_wait_x, 1'b0} : {4'h0, i_wait_x}; // [RL11]
      y_eff = i_y_double ? {3'h0, i_wait_y, 1'b0} : {4'h0, i_wait_y}; // [RL11]
      unique case (i_mode)
         AM_NORMAL:   add = DIV_ADD_NORM + x_eff; // [RL10]
         AM_INDEX:    add = DIV_ADD_INDEX + x_eff; // [RL10]
         AM_INDIRECT: add = DIV_ADD_IND + x_eff + {y_eff[6:0], 1'b0}; // [RL10]
         default:     add = DIV_ADD_INDIDX + x_eff + {y_eff[6:0], 1'b0}; // [RL10]
      endcase
      o_cycles = i_mem_divisor ? DIV_BASE + add : DIV_BASE; // [RL9] [RL25]
   end
endmodule : divide_time_calc

// ---- dv/core_mem_model.sv ----
`timescale 1ns/1ps
// =====
// Core side: stack memory and info word
module core_mem_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_push,
   input  wire logic        i_pop,
   input  wire logic        i_rd,
   input  wire logic [15:0] i_wdata,
   input  wire logic [15:0] i_info,
   output logic      [15:0] o_rdata
);
   logic [15:0] stk [16];
   logic [3:0]  sp;
   logic [15:0] junk;
   // Idle bus toggles so a stale word is never read back
   assign o_rdata = i_pop ? stk[sp - 4'h1] : (i_rd ? i_info : junk);
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sp <= 4'h0;
         junk <= 16'h5A5A;
      end else begin
         junk <= ~junk;
         if (i_push) stk[sp] <= i_wdata;
         sp <= sp + {3'h0, i_push} - {3'h0, i_pop};
      end
   end
endmodule : core_mem_model

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
   import irq_seq_pkg::*;
   logic i_ref_clk = 0, i_rst_n = 0, i_reset_irq = 0, i_nmi_req = 0, i_wdt_req = 0, str = 0;
   logic i_periph_req = 0, i_periph_fast = 0, i_step_req = 0, i_amatch_req = 0, i_trap_req = 0;
   logic i_instr_done = 0, i_string_busy = 0, i_bus8 = 0, i_vec_odd = 0, i_ret_req = 0;
   logic i_fast_ret_req = 0, i_div_mem = 0, i_div_x_double = 0, i_div_y_double = 0;
   logic o_busy, o_suspend, o_info_rd, o_req_clear, o_push, o_pop, o_flag_wr, o_pc_wr;
   logic o_handler_go, o_resume;
   logic [2:0]  i_periph_level = 0, lv;
   logic [5:0]  i_trap_num = 0;
   logic [3:0]  i_div_wait_x = 0, i_div_wait_y = 0, sp0;
   logic [15:0] i_flag_word = 0, i_mem_rdata, info = 0, f, fw, o_mem_wdata, o_flag_out, o_flag_shadow;
   logic [23:0] i_pc = 0, p, ia, o_mem_addr, o_pc_out, o_pc_shadow;
   logic [7:0]  o_int_number, o_divide_cycles;
   logic [4:0]  o_entry_cycles;
   logic [31:0] r, r2;
   class_t      i_trap_class = CL_TRAP;
   div_mode_t   i_div_mode = AM_NORMAL;
   int          n_tests = 0, n_mismatch = 0, cyc = 0, n, sus, nf, k, seed = 32'hECEE;
   class_t      tc [6] = '{CL_TRAP, CL_UNDEF, CL_OVF, CL_BRK_VAR, CL_BRK_FIX, CL_SECOND_BREAK_INSTRUCTION};
   class_t      pq [3] = '{CL_WDT, CL_STEP, CL_RESET};
   logic [6:0]  pr [3] = '{7'h1C, 7'h06, 7'h60};
   logic [2:0]  pl [3] = '{3'h7, 3'h2, 3'h0};
   interrupt_entry_sequencer interrupt_entry_sequencer_i (.*);
   core_mem_model core_mem_model_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_push(o_push),
      .i_pop(o_pop), .i_rd(o_info_rd), .i_wdata(o_mem_wdata), .i_info(info), .o_rdata(i_mem_rdata));
   always #2.5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         test_done;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : test_done
   function automatic logic [4:0] exp_len(input class_t c);
      case (c)
         CL_FAST: return 5'h05;
         CL_PERIPH: return (i_bus8 | i_vec_odd) ? 5'h10 : 5'h0E;
         CL_OVF: return i_bus8 ? 5'h10 : 5'h0E;
         CL_TRAP: return (i_bus8 | i_vec_odd) ? 5'h0E : 5'h0C;
         CL_BRK_VAR: return (i_bus8 | i_vec_odd) ? 5'h13 : 5'h11;
         CL_BRK_FIX, CL_SECOND_BREAK_INSTRUCTION, CL_STEP: return i_bus8 ? 5'h15 : 5'h13;
         default: return i_bus8 ? 5'h0F : 5'h0D;
      endcase
   endfunction : exp_len
   function automatic logic [7:0] exp_div();
      logic [7:0] x, y;
      x = i_div_x_double ? {3'h0, i_div_wait_x, 1'b0} : {4'h0, i_div_wait_x};
      y = i_div_y_double ? {2'h0, i_div_wait_y, 2'h0} : {3'h0, i_div_wait_y, 1'b0};
      if (!i_div_mem) return 8'h18;
      case (i_div_mode)
         AM_NORMAL: return 8'h1A + x;
         AM_INDEX: return 8'h1B + x;
         AM_INDIRECT: return 8'h1D + x + y;
         default: return 8'h1E + x + y;
      endcase
   endfunction : exp_div
   task ret(input logic fa);
      {i_fast_ret_req, i_ret_req} = {fa, !fa};
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
         {i_ret_req, i_fast_ret_req} = 2'h0;
      end while (!o_resume && n < 20);
      chk(o_flag_out, f);
      chk(o_pc_out, p);
   endtask : ret
   task entry(input logic [6:0] rq, input class_t ec, input logic [2:0] el);
      {i_reset_irq, i_nmi_req, i_wdt_req, i_periph_req, i_step_req, i_amatch_req, i_trap_req} = rq;
      {i_instr_done, i_string_busy, f, p, sp0} = {!str, str, i_flag_word, i_pc, core_mem_model_i.sp};
      {n, sus, nf} = 96'h0;
      do begin
         @(negedge i_ref_clk);
         n++;
         i_instr_done = 0;
         if (o_suspend) sus++;
         if (o_info_rd) ia = o_mem_addr;
         if (o_flag_wr && nf++ == 0) fw = o_flag_out;
      end while (!o_handler_go && n < 40);
      {i_reset_irq, i_nmi_req, i_wdt_req, i_periph_req, i_step_req, i_amatch_req} = 6'h00;
      {i_trap_req, i_string_busy} = 2'h0;
      chk(n, exp_len(ec) + 1);
      chk(o_flag_out[14:12], el);
      chk({fw[7], fw[6], fw[2]}, {f[7] & ec == CL_TRAP & i_trap_num[5], 2'h0});
      chk(sus, str);
      chk(4'(core_mem_model_i.sp - sp0), ec == CL_FAST ? 0 : 3);
      if (ec == CL_FAST) begin
         chk(o_flag_shadow, f);
         chk(o_pc_shadow, p);
      end else begin
         chk(core_mem_model_i.stk[sp0], f);
         chk(core_mem_model_i.stk[sp0 + 4'h1], p[23:16]);
         chk(core_mem_model_i.stk[sp0 + 4'h2], p[15:0]);
      end
      if (ec == CL_FAST || ec == CL_PERIPH) begin
         chk(ia, ec == CL_FAST ? FAST_INFO_ADDR : INFO_ADDR);
         chk(o_int_number, info[7:0]);
         ret(ec == CL_FAST);
      end
      $display("entry %0d done", ec);
   endtask : entry
   initial begin
      repeat (4) @(negedge i_ref_clk);
      {i_rst_n, i_periph_req, i_periph_level} = 5'h1D;
      for (k = 0; k < 2; k++) begin
         {i_flag_word, i_instr_done} = {k ? 16'h5040 : 16'h3000, 1'b1};
         repeat (6) begin
            @(negedge i_ref_clk);
            i_instr_done = 0;
            chk(o_busy, 1'b0);
         end
      end
      for (k = 0; k < 6; k++) begin
         {r, r2} = {$random(seed), $random(seed)};
         lv = 3'h4 + {1'b0, r[4:3]};
         i_flag_word = {r[31], 1'b0, r[1:0], r[27:16]} | 16'h0040;
         {i_pc, i_bus8, i_vec_odd, str, i_periph_fast} = {r2[23:0], r[7:5], k > 3};
         {i_periph_level, info} = {lv, 5'h00, lv, r2[31:24]};
         entry(7'h08, i_periph_fast ? CL_FAST : CL_PERIPH, lv);
      end
      for (k = 0; k < 6; k++) begin
         r = $random(seed);
         {i_flag_word, i_trap_num, i_bus8, i_vec_odd, str} = {r[23:0], 1'b0};
         i_trap_class = tc[k];
         entry(7'h01, tc[k], r[22:20]);
      end
      {i_flag_word, i_periph_level, i_periph_fast} = {16'h2040, 3'h3, 1'b0};
      for (k = 0; k < 3; k++) entry(pr[k], pq[k], pl[k]);
      for (k = 0; k < 8; k++) begin
         r = $random(seed);
         i_div_mode = div_mode_t'(r[13:12]);
         i_amatch_req = r[11];
         {i_div_mem, i_div_wait_x, i_div_wait_y, i_div_x_double, i_div_y_double} = r[10:0];
         @(negedge i_ref_clk);
         chk(o_divide_cycles, exp_div());
      end
      test_done;
   end
endmodule : tb
